//--- design/uaf_pkg.sv
// Package for the UART address filter and shared register select block.
// Assumes a single 50 MHz clock with synchronous active-high reset.
package uaf_pkg;
   // Oversampling and majority-vote sample numbers
   localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
   // Register locations on the byte-wide CPU port
   localparam logic [2:0] ADDR_DATA_PORT = 3'h0;
   localparam logic [2:0] ADDR_CTRL_STATUS_A = 3'h1;
   localparam logic [2:0] ADDR_BAUD_LOW = 3'h2;
   localparam logic [2:0] ADDR_SHARED = 3'h3;
   // Bit positions in ctrl_status_a
   localparam int BIT_RXC = 7;
   localparam int BIT_TXC = 6;
   localparam int BIT_UDRE = 5;
   localparam int BIT_FE = 4;
   localparam int BIT_DOUBLE = 1;
   localparam int BIT_FILTER = 0;
   // Bit positions in the frame format register
   localparam int BIT_SELECT = 7;
   localparam int BIT_STOP2 = 3;
   // Reset values
   localparam logic [7:0] FMT_RESET = 8'h86;
   localparam logic [3:0] BAUD_HIGH_RESET = 4'h0;
   localparam logic [7:0] BAUD_LOW_RESET = 8'h00;
   localparam int FIFO_DEPTH = 8;
   localparam int FRAME_W = 11;
   localparam logic [2:0] SIZE_NINE = 3'h7;
endpackage

//--- design/uaf_if.sv
// Interface joining the two ends: one serial line each way.
// Assumes both ends run on the same clock; line idle is high.
`timescale 1ns/10ps
`default_nettype none
interface uaf_if;
   logic line_to_dev;
   logic line_to_far;
   modport dev (input line_to_dev, output line_to_far);
   modport far (output line_to_dev, input line_to_far);
endinterface
`default_nettype wire

//--- design/uaf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/10ps
`default_nettype none
module uaf_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // Count is one bit wider than the pointers so full and empty differ
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   // Storage is not reset; only the pointers matter
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wp_q] <= in_data;
   end
   // Pointers and fill count
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

//--- design/uaf_far_end.sv
// Far end: a bus master sending 9-bit frames with an address marker.
// Assumes the device samples the line at the same bit rate.
`timescale 1ns/10ps
`default_nettype none
module uaf_far_end (
   input wire logic clk,
   input wire logic rst,
   uaf_if.far link,
   input wire logic [11:0] baud_divisor,
   input wire logic send_valid,
   output logic send_ready,
   input wire logic [7:0] send_data,
   input wire logic send_is_addr
);
   logic [11:0] div_q;
   logic [3:0] tick_q;
   logic [3:0] bit_q;
   logic [10:0] sh_q;
   logic busy_q;
   logic line_q;
   wire tick = (div_q == '0);
   wire bit_end = tick && (tick_q == 4'hF);
   assign send_ready = !busy_q;
   assign link.line_to_dev = line_q;
   // Nine data bits, ninth bit marks address frames, two stop bits
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_q <= '0;
         tick_q <= '0;
         bit_q <= '0;
         sh_q <= '1;
         busy_q <= 1'b0;
         line_q <= 1'b1;
      end
      else if (!busy_q)
      begin
         div_q <= baud_divisor;
         tick_q <= '0;
         if (send_valid)
         begin
            busy_q <= 1'b1;
            line_q <= 1'b0;
            // Start bit is already on the line; data LSB first, type bit, two stops
            sh_q <= {2'b11, send_is_addr, send_data};
            bit_q <= 4'hB;
         end
      end
      else
      begin
         div_q <= tick ? baud_divisor : div_q - 1'b1;
         if (tick)
            tick_q <= tick_q + 1'b1;
         if (bit_end)
         begin
            line_q <= sh_q[0];
            sh_q <= {1'b1, sh_q[10:1]};
            bit_q <= bit_q - 1'b1;
            if (bit_q == 4'h0)
               busy_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- design/uaf_dev_end.sv
// Device end: receiver with address filter and the shared register select.
// Assumes a byte-wide synchronous CPU port; rx line is asynchronous.
// Behaviour
// - 16 samples normal, 8 double speed
// - Vote first sample 8 or 4
// - Vote middle sample 9 or 5
// - Data plus parity bits 5 to 10; the code gives 5 to 12, as fmt_q[2] fills two size bits
// - Normal speed accepts 95.36 to 104.58 percent
// - Double speed accepts 96.00 to 103.90 percent
// - Each end keeps baud error near half
// - Filter on drops non-address frames
// - Transmitter ignores the filter enable
// - Frame type: stop bit or ninth bit
// - Type one address, zero data
// - Address frames stored as normal
// - Filtering continues until next address frame
// - Master uses nine bits, marks addresses
// - Slave software toggles filter per address
// - One character size for both directions
// - Short frames need two stop bits
// - Filter shares location with tx complete
// - Baud high and format share address
// - Top written bit selects write target
// - Back-to-back read returns format register
// - Start bit voted on 8,9,10 or 4,5,6
`timescale 1ns/10ps
`default_nettype none
module uaf_dev_end (
   input wire logic clk,
   input wire logic rst,
   uaf_if.dev link,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [2:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata
);
   typedef enum logic [2:0] {
      UAF_IDLE = 3'b001,
      UAF_START = 3'b010,
      UAF_BITS = 3'b100
   } uaf_rx_e;
   uaf_rx_e st_q;
   logic rx_meta_q, rx_sync_q;
   logic [3:0] baud_high_q;
   logic [7:0] baud_low_q;
   logic [7:0] fmt_q;
   logic filter_q, double_q, txc_q;
   logic prev_shared_rd_q;
   logic [7:0] rdata_q;
   logic [11:0] div_q;
   logic [4:0] samp_q;
   logic [3:0] bitn_q;
   logic [3:0] nbits;
   logic [2:0] votes_q;
   logic [9:0] shift_q;
   logic push_q;
   logic [10:0] push_data_q;
   logic [10:0] head;
   logic head_valid;
   logic fifo_in_ready;
   // Shared character size for both directions
   wire [2:0] char_size_sel = {fmt_q[2], fmt_q[2:1]};
   wire nine = (char_size_sel == uaf_pkg::SIZE_NINE);
   wire parity_on = fmt_q[5];
   wire [4:0] spb = double_q ? uaf_pkg::SAMPLES_DOUBLE : uaf_pkg::SAMPLES_NORMAL;
   wire [4:0] vfirst = double_q ? uaf_pkg::VOTE_FIRST_DOUBLE : uaf_pkg::VOTE_FIRST_NORMAL;
   wire [4:0] vmid = vfirst + 5'h01;
   wire [4:0] vlast = vfirst + 5'h02;
   wire tick = (div_q == '0);
   wire in_vote = tick && (samp_q == vfirst || samp_q == vmid || samp_q == vlast);
   wire vote = (votes_q[1] & votes_q[0]) | (votes_q[1] & rx_sync_q) | (votes_q[0] & rx_sync_q);
   wire bit_done = tick && (samp_q == vlast);
   // Data plus parity between 5 and 12, plus one stop bit
   assign nbits = 4'(5 + {1'b0, char_size_sel == 3'h7 ? 3'h4 : char_size_sel}) + 4'(parity_on);
   wire shared_wr = bus_wr && bus_addr == uaf_pkg::ADDR_SHARED;
   wire shared_rd = bus_rd && bus_addr == uaf_pkg::ADDR_SHARED;
   wire a_wr = bus_wr && bus_addr == uaf_pkg::ADDR_CTRL_STATUS_A;
   wire d_rd = bus_rd && bus_addr == uaf_pkg::ADDR_DATA_PORT;
   // Buffer storage is not reset, so an empty buffer must not show a stale error
   wire fe_flag = head_valid && head[9];
   wire [7:0] ctrl_status_a = {head_valid, txc_q, 1'b1, fe_flag, 2'b00, double_q, filter_q};
   assign link.line_to_far = 1'b1; // Transmitter idle; never looks at filter_q
   assign bus_rdata = rdata_q;
   // Line synchroniser
   always_ff @(posedge clk)
   begin
      rx_meta_q <= rst ? 1'b1 : link.line_to_dev;
      rx_sync_q <= rst ? 1'b1 : rx_meta_q;
   end
   // Register writes; top bit picks baud high or format
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         baud_high_q <= uaf_pkg::BAUD_HIGH_RESET;
         baud_low_q <= uaf_pkg::BAUD_LOW_RESET;
         fmt_q <= uaf_pkg::FMT_RESET;
         filter_q <= 1'b0;
         double_q <= 1'b0;
         txc_q <= 1'b0;
      end
      else
      begin
         if (shared_wr && !bus_wdata[uaf_pkg::BIT_SELECT])
            baud_high_q <= bus_wdata[3:0];
         if (shared_wr && bus_wdata[uaf_pkg::BIT_SELECT])
            fmt_q <= bus_wdata | 8'h80;
         if (bus_wr && bus_addr == uaf_pkg::ADDR_BAUD_LOW)
            baud_low_q <= bus_wdata;
         if (a_wr)
         begin
            filter_q <= bus_wdata[uaf_pkg::BIT_FILTER];
            double_q <= bus_wdata[uaf_pkg::BIT_DOUBLE];
            if (bus_wdata[uaf_pkg::BIT_TXC])
               txc_q <= 1'b0;
         end
      end
   end
   // Reads; second read of shared address in a row gives format
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         prev_shared_rd_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         prev_shared_rd_q <= shared_rd;
         if (shared_rd)
            rdata_q <= prev_shared_rd_q ? fmt_q : {4'h0, baud_high_q};
         else if (d_rd)
            rdata_q <= head[7:0];
         else if (bus_rd && bus_addr == uaf_pkg::ADDR_CTRL_STATUS_A)
            rdata_q <= ctrl_status_a;
         else if (bus_rd)
            rdata_q <= 8'h00;
      end
   end
   // Receiver: sample counter, vote, frame assembly, filter
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= UAF_IDLE;
         div_q <= '0;
         samp_q <= '0;
         bitn_q <= '0;
         votes_q <= '0;
         shift_q <= '0;
         push_q <= 1'b0;
         push_data_q <= '0;
      end
      else
      begin
         push_q <= 1'b0;
         div_q <= tick ? {baud_high_q, baud_low_q} : div_q - 1'b1;
         if (in_vote)
            votes_q <= {votes_q[1:0], rx_sync_q};
         case (st_q)
            UAF_IDLE:
            begin
               samp_q <= 5'h02; // Edge seen here is sample 1; next tick is 2
               div_q <= {baud_high_q, baud_low_q};
               if (!rx_sync_q)
                  st_q <= UAF_START;
            end
            UAF_START:
            begin
               if (tick)
                  samp_q <= (samp_q == spb) ? 5'h01 : samp_q + 5'h01;
               if (bit_done)
               begin
                  bitn_q <= '0;
                  st_q <= vote ? UAF_IDLE : UAF_BITS;
               end
            end
            UAF_BITS:
            begin
               if (tick)
                  samp_q <= (samp_q == spb) ? 5'h01 : samp_q + 5'h01;
               if (bit_done)
               begin
                  shift_q <= {vote, shift_q[9:1]};
                  bitn_q <= bitn_q + 4'h1;
                  if (bitn_q == nbits)
                  begin
                     st_q <= UAF_IDLE;
                     // Type bit is the ninth bit or the first stop bit
                     // Data frames are dropped while filtering
                     push_q <= !filter_q || (nine ? shift_q[9] : vote);
                     push_data_q <= {1'b0, !vote, nine ? shift_q[9] : vote, 8'h00}
                        | 11'({shift_q[9:1], vote} >> (4'hA - nbits));
                  end
               end
            end
            default:
               st_q <= UAF_IDLE;
         endcase
      end
   end
   uaf_fifo #(.WIDTH(uaf_pkg::FRAME_W), .DEPTH(uaf_pkg::FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_q && fifo_in_ready),
      .in_ready(fifo_in_ready),
      .in_data(push_data_q),
      .out_valid(head_valid),
      .out_ready(d_rd),
      .out_data(head)
   );
endmodule
`default_nettype wire

//--- dv/uaf_link_chk.sv
// Checker on the serial line between the two ends.
// Assumes a baud divisor of zero, so each bit lasts 16 clocks.
`timescale 1ns/10ps
`default_nettype none
module uaf_link_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_to_dev,
   input wire logic line_to_far
);
   logic [7:0] pos_q;
   logic [7:0] pos_d;
   logic frame_edge;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Clock index in a 176-clock frame; the first low clock is index zero
   assign frame_edge = (pos_q == 8'h00) || (pos_q == 8'hAF);
   assign pos_d = frame_edge ? {7'h00, !line_to_dev} : pos_q + 8'h01;
   // Counter restarts on reset so a frame cut short is not judged
   always_ff @(posedge clk)
   begin
      if (rst)
         pos_q <= 8'h00;
      else
         pos_q <= pos_d;
   end
   chk_tx_line_idle: assert property (line_to_far == 1'b1)
      else $error("device drives its transmit line low");
   chk_start_bit_low: assert property (pos_q inside {[1:15]} |-> !line_to_dev)
      else $error("start bit shorter than 16 clocks");
   chk_stop_bit_high: assert property (pos_q >= 8'hA0 |-> line_to_dev)
      else $error("stop bit low on the line");
   chk_bit_cell_steady: assert property
      ((pos_q != 8'h00 && pos_q[3:0] != 4'hF) |=> $stable(line_to_dev))
      else $error("line changed inside a bit cell");
   // The count restarts after the first stop bit, so the second one is timed from there
   chk_second_stop_high: assert property
      (pos_q == 8'hAF |=> line_to_dev [*8] ##1 line_to_dev [*8])
      else $error("second stop bit cut short");
   chk_cell_edge_only: assert property
      ($changed(line_to_dev) |-> pos_q[3:0] == 4'h0)
      else $error("line changed off a bit cell boundary");
   // Both frame kinds must appear for the filter to be exercised
   cover property (pos_q == 8'h01);
   cover property (pos_q == 8'h90 && line_to_dev);
   cover property (pos_q == 8'h90 && !line_to_dev);
endmodule
`default_nettype wire

//--- dv/uart_addr_filter_regselect_tb_top.sv
// Testbench: both ends joined by the interface, CPU port driven by tasks.
// Assumes a baud divisor of zero, so a frame with two stop bits takes 192 clocks.
`timescale 1ns/10ps
`default_nettype none
module uart_addr_filter_regselect_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bus_rd = 1'b0;
   logic bus_wr = 1'b0;
   logic [2:0] bus_addr = 3'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic [7:0] bus_rdata;
   logic send_valid = 1'b0;
   logic send_ready;
   logic [7:0] send_data = 8'h00;
   logic send_is_addr = 1'b0;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   uaf_if link ();
   uaf_dev_end uaf_dev_end_i (.clk(clk), .rst(rst), .link(link), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
   uaf_far_end uaf_far_end_i (.clk(clk), .rst(rst), .link(link), .baud_divisor(12'h000),
      .send_valid(send_valid), .send_ready(send_ready), .send_data(send_data),
      .send_is_addr(send_is_addr));
   uaf_link_chk uaf_link_chk_i (.clk(clk), .rst(rst), .line_to_dev(link.line_to_dev),
      .line_to_far(link.line_to_far));
   // Clock at 50 MHz
   always #10 clk = ~clk;
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, well above the roughly 2600 clocks the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         results();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // One read, or two in adjacent cycles; data is registered, so look a cycle on
   task automatic rd(input logic [2:0] a, input int n, input logic [7:0] e1,
      input logic [7:0] e2);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      if (n == 1)
         bus_rd <= 1'b0;
      @(negedge clk);
      check("read data", e1, bus_rdata);
      if (n == 2)
      begin
         @(posedge clk);
         bus_rd <= 1'b0;
         @(negedge clk);
         check("second read", e2, bus_rdata);
      end
   endtask
   // Ready is combinational, so it is looked at half a cycle before the taking edge
   task automatic send(input logic [7:0] d, input logic is_addr);
      @(posedge clk);
      send_valid <= 1'b1;
      send_data <= d;
      send_is_addr <= is_addr;
      @(negedge clk);
      while (!send_ready)
         @(negedge clk);
      @(posedge clk);
      send_valid <= 1'b0;
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'h20, 8'h00);
      rd(uaf_pkg::ADDR_SHARED, 2, 8'h00, uaf_pkg::FMT_RESET);
      wr(uaf_pkg::ADDR_SHARED, 8'h02);
      wr(uaf_pkg::ADDR_SHARED, 8'h8E);
      rd(uaf_pkg::ADDR_SHARED, 2, 8'h02, 8'h8E);
      wr(uaf_pkg::ADDR_SHARED, 8'h00);
      wr(uaf_pkg::ADDR_SHARED, uaf_pkg::FMT_RESET);
      wr(uaf_pkg::ADDR_CTRL_STATUS_A, 8'h41);
      rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'h21, 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         send(8'h3C, 1'b0);
         repeat (200) @(posedge clk);
         rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'h21, 8'h00);
      end
      send(8'hA5, 1'b1);
      repeat (200) @(posedge clk);
      rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'hA1, 8'h00);
      rd(uaf_pkg::ADDR_DATA_PORT, 1, 8'hA5, 8'h00);
      wr(uaf_pkg::ADDR_CTRL_STATUS_A, 8'h00);
      // Nine frames into eight places: the last is lost
      for (int i = 0; i < 9; i++)
         send(8'h10 + 8'(i), 1'b0);
      repeat (200) @(posedge clk);
      for (int i = 0; i < 8; i++)
         rd(uaf_pkg::ADDR_DATA_PORT, 1, 8'h10 + 8'(i), 8'h00);
      rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'h20, 8'h00);
      // Double speed: 8 samples two clocks apart still fill one 16-clock cell
      wr(uaf_pkg::ADDR_BAUD_LOW, 8'h01);
      wr(uaf_pkg::ADDR_CTRL_STATUS_A, 8'h02);
      send(8'h5A, 1'b0);
      repeat (200) @(posedge clk);
      rd(uaf_pkg::ADDR_CTRL_STATUS_A, 1, 8'hA2, 8'h00);
      rd(uaf_pkg::ADDR_DATA_PORT, 1, 8'h5A, 8'h00);
      results();
   end
endmodule
`default_nettype wire
